/* hdl/periph_irq_pkg.sv */
package periph_irq_pkg;

    // Register offsets
    localparam logic [8:0] ADDR_FLAGS_ONE   = 9'h00_0C;
    localparam logic [8:0] ADDR_ENABLES_ONE = 9'h00_8C;
    localparam logic [8:0] ADDR_ENABLES_TWO = 9'h00_8D;
    localparam logic [8:0] ADDR_FLAGS_TWO   = 9'h00_0D;
    localparam logic [8:0] ADDR_CORE_CTRL   = 9'h00_0B;

    // Field positions
    localparam int BIT_CONV_DONE   = 6;
    localparam int BIT_SERIAL      = 3;
    localparam int BIT_CAPCMP      = 2;
    localparam int BIT_PERIOD      = 1;
    localparam int BIT_WIDE_OVF    = 0;
    localparam int BIT_MEM_WRITE   = 4;
    localparam int BIT_GLOBAL_EN   = 7;
    localparam int BIT_GROUP_EN    = 6;

    // Implemented bit masks
    localparam logic [7:0] MASK_ONE  = 8'h4F;
    localparam logic [7:0] MASK_TWO  = 8'h10;
    localparam logic [7:0] MASK_CORE = 8'hC0;

    // Reset values
    localparam logic [7:0] RESET_REG = 8'h00;

    // Capture/compare unit modes
    typedef enum logic [1:0] {
        MODE_OFF,
        MODE_CAPTURE,
        MODE_COMPARE,
        MODE_PWM
    } capcmp_mode_t;

    // Peripheral event strobes
    typedef struct packed {
        logic conv_done;
        logic serial_done;
        logic capture;
        logic compare_match;
        logic period_match;
        logic wide_timer_ovf;
        logic mem_write_done;
    } periph_events_t;

    // Register port request
    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

endpackage

/* hdl/peripheral_interrupt_flags.sv */
`timescale 1ns/1ps
module peripheral_interrupt_flags
    import periph_irq_pkg::*;
(
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           rst_n,
    // Register port
    input  wire reg_req_t       req,
    output logic [7:0]          rdata,
    // Peripheral events
    input  wire periph_events_t events,
    input  wire capcmp_mode_t   capcmp_mode,
    // CPU request
    output logic                irq
);

    // Write strobes per register
    logic             wr_flags_one;
    logic             wr_flags_two;
    logic             wr_enables_one;
    logic             wr_enables_two;
    logic             wr_core;

    // Read strobes per register
    logic             rd_flags_one;
    logic             rd_flags_two;
    logic             rd_enables_one;
    logic             rd_enables_two;
    logic             rd_core;

    // Event set vectors
    logic             capcmp_evt;
    logic [7:0]       set_one;
    logic [7:0]       set_two;

    // Flag vectors built bit by bit
    wire  logic [7:0] flags_one;
    wire  logic [7:0] flags_one_nx;
    wire  logic [7:0] flags_two;
    wire  logic [7:0] flags_two_nx;

    // Enable registers
    logic [7:0]       enables_one_q;
    logic [7:0]       enables_one_d;
    logic [7:0]       enables_two_q;
    logic [7:0]       enables_two_d;
    logic [7:0]       core_ctrl_q;
    logic [7:0]       core_ctrl_d;

    // Read path
    logic [7:0]       rdata_q;
    logic [7:0]       rdata_d;

    // Request path
    wire  logic [7:0] pend_one;
    wire  logic [7:0] pend_two;
    logic             pend_one_any;
    logic             pend_two_any;
    logic             pend_any;
    logic             gate_open;
    logic             irq_q;
    logic             irq_d;

    // Strobe aimed at one address
    function automatic logic hit(input logic       strobe,
                                 input logic [8:0] addr,
                                 input logic [8:0] target);
        hit = strobe && (addr == target);
    endfunction

    // Next value of a writable register, unimplemented bits held at zero
    function automatic logic [7:0] next_reg(input logic       we,
                                            input logic [7:0] wdata,
                                            input logic [7:0] cur,
                                            input logic [7:0] mask);
        if (we) begin
            next_reg = wdata & mask;
        end else begin
            next_reg = cur & mask;
        end
    endfunction

    // Address decode of the write strobe
    always_comb begin
        wr_flags_one   = hit(req.wr, req.addr, ADDR_FLAGS_ONE);
        wr_flags_two   = hit(req.wr, req.addr, ADDR_FLAGS_TWO);
        wr_enables_one = hit(req.wr, req.addr, ADDR_ENABLES_ONE);
        wr_enables_two = hit(req.wr, req.addr, ADDR_ENABLES_TWO);
        wr_core        = hit(req.wr, req.addr, ADDR_CORE_CTRL);
    end

    // Address decode of the read strobe
    always_comb begin
        rd_flags_one   = hit(req.rd, req.addr, ADDR_FLAGS_ONE);
        rd_flags_two   = hit(req.rd, req.addr, ADDR_FLAGS_TWO);
        rd_enables_one = hit(req.rd, req.addr, ADDR_ENABLES_ONE);
        rd_enables_two = hit(req.rd, req.addr, ADDR_ENABLES_TWO);
        rd_core        = hit(req.rd, req.addr, ADDR_CORE_CTRL);
    end

    // Capture/compare event by mode
    always_comb begin
        capcmp_evt = 1'b0;
        case (capcmp_mode)
            MODE_CAPTURE: begin
                capcmp_evt = events.capture;
            end
            MODE_COMPARE: begin
                capcmp_evt = events.compare_match;
            end
            MODE_PWM: begin
                capcmp_evt = 1'b0;
            end
            default: begin
                capcmp_evt = 1'b0;
            end
        endcase
    end

    // Set vector of the first flag register
    always_comb begin
        set_one = 8'h00;
        set_one[BIT_CONV_DONE] = events.conv_done;
        set_one[BIT_SERIAL]    = events.serial_done;
        set_one[BIT_CAPCMP]    = capcmp_evt;
        set_one[BIT_PERIOD]    = events.period_match;
        set_one[BIT_WIDE_OVF]  = events.wide_timer_ovf;
    end

    // Set vector of the second flag register
    always_comb begin
        set_two = 8'h00;
        set_two[BIT_MEM_WRITE] = events.mem_write_done;
    end

    // Per-bit storage of the first flag register
    for (genvar b = 0; b < 8; b++) begin : g_flags_one
        if (MASK_ONE[b]) begin : g_impl
            logic flag_q;
            logic flag_d;

            always_comb begin
                flag_d = flag_q;
                if (wr_flags_one) begin
                    flag_d = req.wdata[b];
                end
                if (set_one[b]) begin
                    flag_d = 1'b1;
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    flag_q <= RESET_REG[b];
                end else begin
                    flag_q <= flag_d;
                end
            end

            assign flags_one[b]    = flag_q;
            assign flags_one_nx[b] = flag_d;
        end else begin : g_unimpl
            assign flags_one[b]    = 1'b0;
            assign flags_one_nx[b] = 1'b0;
        end
    end

    // Per-bit storage of the second flag register
    for (genvar b = 0; b < 8; b++) begin : g_flags_two
        if (MASK_TWO[b]) begin : g_impl
            logic flag_q;
            logic flag_d;

            always_comb begin
                flag_d = flag_q;
                if (wr_flags_two) begin
                    flag_d = req.wdata[b];
                end
                if (set_two[b]) begin
                    flag_d = 1'b1;
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    flag_q <= RESET_REG[b];
                end else begin
                    flag_q <= flag_d;
                end
            end

            assign flags_two[b]    = flag_q;
            assign flags_two_nx[b] = flag_d;
        end else begin : g_unimpl
            assign flags_two[b]    = 1'b0;
            assign flags_two_nx[b] = 1'b0;
        end
    end

    // Next value of the first enable register
    always_comb begin
        enables_one_d = next_reg(wr_enables_one, req.wdata, enables_one_q, MASK_ONE);
    end

    // Next value of the second enable register
    always_comb begin
        enables_two_d = next_reg(wr_enables_two, req.wdata, enables_two_q, MASK_TWO);
    end

    // Next value of the core control register
    always_comb begin
        core_ctrl_d = next_reg(wr_core, req.wdata, core_ctrl_q, MASK_CORE);
    end

    // First enable register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enables_one_q <= RESET_REG;
        end else begin
            enables_one_q <= enables_one_d;
        end
    end

    // Second enable register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enables_two_q <= RESET_REG;
        end else begin
            enables_two_q <= enables_two_d;
        end
    end

    // Core control register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            core_ctrl_q <= RESET_REG;
        end else begin
            core_ctrl_q <= core_ctrl_d;
        end
    end

    // Read data, one cycle after the strobe
    always_comb begin
        rdata_d = 8'h00;
        if (rd_flags_one) begin
            rdata_d = flags_one & MASK_ONE;
        end
        if (rd_flags_two) begin
            rdata_d = flags_two & MASK_TWO;
        end
        if (rd_enables_one) begin
            rdata_d = enables_one_q & MASK_ONE;
        end
        if (rd_enables_two) begin
            rdata_d = enables_two_q & MASK_TWO;
        end
        if (rd_core) begin
            rdata_d = core_ctrl_q & MASK_CORE;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= RESET_REG;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Per-bit pairing of flags and enables
    for (genvar p = 0; p < 8; p++) begin : g_pend
        assign pend_one[p] = flags_one_nx[p] & enables_one_q[p];
        assign pend_two[p] = flags_two_nx[p] & enables_two_q[p];
    end

    // Any pending pair per register
    always_comb begin
        pend_one_any = |pend_one;
        pend_two_any = |pend_two;
    end

    // Any pending pair
    always_comb begin
        pend_any = pend_one_any || pend_two_any;
    end

    // Global and group gate
    always_comb begin
        gate_open = core_ctrl_q[BIT_GLOBAL_EN] && core_ctrl_q[BIT_GROUP_EN];
    end

    // Request to CPU
    always_comb begin
        irq_d = gate_open && pend_any;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    assign rdata = rdata_q;
    assign irq   = irq_q;

endmodule

/* tb/periph_irq_asserts.sv */
`timescale 1ns/1ps
module periph_irq_asserts
    import periph_irq_pkg::*;
(
    // Watched ports
    input wire logic           clk,
    input wire logic           rst_n,
    input wire reg_req_t       req,
    input wire logic [7:0]     rdata,
    input wire periph_events_t events,
    input wire capcmp_mode_t   capcmp_mode,
    input wire logic           irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic known = req.addr inside {ADDR_FLAGS_ONE, ADDR_ENABLES_ONE,
                                        ADDR_ENABLES_TWO, ADDR_FLAGS_TWO, ADDR_CORE_CTRL};
    sequence s_rd1; req.rd && req.addr == ADDR_FLAGS_ONE; endsequence
    sequence s_cw;
        req.wr && req.addr == ADDR_CORE_CTRL && !(req.wdata[BIT_GLOBAL_EN] && req.wdata[BIT_GROUP_EN]);
    endsequence
    property p_unmapped; req.rd && !known |=> rdata == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_mask1; s_rd1 |=> (rdata & ~MASK_ONE) == 8'h00; endproperty
    a_mask1: assert property (p_mask1) else $error("flags one mask");
    property p_mask2; req.rd && req.addr == ADDR_ENABLES_TWO |=> (rdata & ~MASK_TWO) == 8'h00; endproperty
    a_mask2: assert property (p_mask2) else $error("enables two mask");
    property p_core; req.rd && req.addr == ADDR_CORE_CTRL |=> (rdata & ~MASK_CORE) == 8'h00; endproperty
    a_core: assert property (p_core) else $error("core mask");
    property p_conv; events.conv_done ##1 s_rd1 |=> rdata[BIT_CONV_DONE]; endproperty
    a_conv: assert property (p_conv) else $error("conversion flag");
    property p_cap; events.capture && capcmp_mode == MODE_CAPTURE ##1 s_rd1 |=> rdata[BIT_CAPCMP]; endproperty
    a_cap: assert property (p_cap) else $error("capture flag");
    property p_cmp; events.compare_match && capcmp_mode == MODE_COMPARE ##1 s_rd1 |=> rdata[BIT_CAPCMP]; endproperty
    a_cmp: assert property (p_cmp) else $error("compare flag");
    property p_gate; s_cw ##1 !(req.wr && req.addr == ADDR_CORE_CTRL) |=> !irq; endproperty
    a_gate: assert property (p_gate) else $error("request not gated");
endmodule
bind peripheral_interrupt_flags periph_irq_asserts i_chk (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
    .events(events), .capcmp_mode(capcmp_mode), .irq(irq));

/* tb/event_source.sv */
`timescale 1ns/1ps
module event_source
    import periph_irq_pkg::*;
(
    // Control and events
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       go,
    input  wire logic [2:0] sel,
    output periph_events_t  events
);
    // One-cycle pulse of the selected source
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) events <= '0;
        else events <= go ? periph_events_t'(7'h40 >> sel) : '0;
    end
endmodule

/* tb/peripheral_interrupt_flags_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module peripheral_interrupt_flags_tb
    import periph_irq_pkg::*;
;
    localparam logic [8:0] AD [6] = '{ADDR_FLAGS_ONE, ADDR_ENABLES_ONE, ADDR_FLAGS_TWO, ADDR_ENABLES_TWO,
                                      ADDR_CORE_CTRL, 9'h000};
    localparam logic [7:0] MK [6] = '{MASK_ONE, MASK_ONE, MASK_TWO, MASK_TWO, MASK_CORE, 8'h00};
    localparam logic [7:0] EX [7] = '{8'h40, 8'h08, 8'h04, 8'h04, 8'h02, 8'h01, 8'h10};
    logic           clk = 0, rst_n = 0, go = 0, irq;
    logic [2:0]     sel = 0;
    logic [7:0]     rdata;
    reg_req_t       req = '0;
    capcmp_mode_t   mode = MODE_OFF;
    periph_events_t ev;
    int             failures = 0, checks_done = 0;
    always #4 clk = ~clk;
    event_source i_src (.clk(clk), .rst_n(rst_n), .go(go), .sel(sel), .events(ev));
    peripheral_interrupt_flags i_dut (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .events(ev),
                                      .capcmp_mode(mode), .irq(irq));
    task automatic wr(logic [8:0] a, logic [7:0] d);
        @(posedge clk) req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk) req.wr <= 0;
    endtask
    task automatic rd(logic [8:0] a, logic [7:0] e);
        @(posedge clk) req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk) req.rd <= 0;
        #1 `CHK("rdata", e, rdata)
    endtask
    task automatic pulse(int i);
        @(posedge clk) begin sel <= 3'(i); go <= 1; end
        @(posedge clk) go <= 0;
    endtask
    task automatic wirq(logic e);
        int n;
        if (!e) repeat (3) @(posedge clk);
        #1;
        for (n = 0; n < 4 && irq !== e; n++) begin
            @(posedge clk);
            #1;
        end
        `CHK("irq", e, irq)
        if (irq !== e) end_of_test();
    endtask
    task automatic t_regs;
        for (int i = 0; i < 6; i++) rd(AD[i], RESET_REG);
        for (int i = 0; i < 6; i++) begin
            wr(AD[i], 8'hFF);
            rd(AD[i], MK[i]);
            wr(AD[i], 8'h00);
        end
        $display("regs done");
    endtask
    task automatic t_flags;
        logic [8:0] f;
        for (int i = 0; i < 7; i++) begin
            f = i == 6 ? ADDR_FLAGS_TWO : ADDR_FLAGS_ONE;
            mode <= i == 3 ? MODE_COMPARE : MODE_CAPTURE;
            pulse(i);
            rd(f, EX[i]);
            rd(f, EX[i]);
            wr(f, 8'h00);
        end
        mode <= MODE_PWM;
        pulse(2);
        pulse(3);
        rd(ADDR_FLAGS_ONE, 8'h00);
        $display("flags done");
    endtask
    task automatic t_each;
        mode <= MODE_CAPTURE;
        pulse(0);
        rd(ADDR_FLAGS_ONE, 8'h40);
        pulse(2);
        rd(ADDR_FLAGS_ONE, 8'h44);
        wr(ADDR_FLAGS_ONE, 8'h00);
        mode <= MODE_COMPARE;
        pulse(2);
        pulse(3);
        rd(ADDR_FLAGS_ONE, 8'h04);
        pulse(4);
        rd(ADDR_FLAGS_ONE, 8'h06);
        pulse(5);
        rd(ADDR_FLAGS_ONE, 8'h07);
        pulse(6);
        rd(ADDR_FLAGS_TWO, 8'h10);
        wr(ADDR_FLAGS_ONE, 8'h00);
        wr(ADDR_FLAGS_TWO, 8'h00);
        rd(ADDR_FLAGS_ONE, 8'h00);
        rd(ADDR_FLAGS_TWO, 8'h00);
        $display("sources done");
    endtask
    task automatic t_irq;
        wr(ADDR_FLAGS_ONE, 8'h00);
        wr(ADDR_ENABLES_ONE, 8'h01);
        wr(ADDR_CORE_CTRL, 8'h80);
        pulse(5);
        wirq(0);
        wr(ADDR_CORE_CTRL, 8'hC0);
        wirq(1);
        wr(ADDR_ENABLES_ONE, 8'h00);
        wirq(0);
        wr(ADDR_ENABLES_TWO, 8'h10);
        pulse(6);
        wirq(1);
        $display("irq done");
    endtask
    task automatic end_of_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1;
        t_regs();
        t_flags();
        t_each();
        t_irq();
        end_of_test();
    end
endmodule
